// *** hw/lighting_regs_pkg.sv ***
package lighting_regs_pkg;
  // function codes and exception answers
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] FC_READ_WRITE = 8'h17;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_BAD_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_BAD_DATA = 8'h03;
  // register addresses as carried in the request
  localparam logic [15:0] RELAY_STATE_FIRST = 16'h80e9;
  localparam logic [15:0] RELAY_STATE_LAST = 16'h80ec;
  localparam logic [15:0] RELAY_CMD_FIRST = 16'ha7f9;
  localparam logic [15:0] RELAY_CMD_LAST = 16'ha7fc;
  localparam logic [15:0] BUS_A_COUNT = 16'h84d1;
  localparam logic [15:0] BUS_A_RECORDS = 16'h84d2;
  localparam logic [15:0] BUS_A_LAST = 16'h85d1;
  localparam logic [15:0] BUS_B_COUNT = 16'h88b9;
  localparam logic [15:0] BUS_B_RECORDS = 16'h88ba;
  localparam logic [15:0] BUS_B_LAST = 16'h89b9;
  localparam logic [15:0] ONE_REG = 16'h0001;
  localparam logic [15:0] MAX_READ_QTY = 16'h007d;
  localparam logic [15:0] MAX_WRITE_QTY = 16'h007b;
  // request header lengths and reply framing
  localparam logic [3:0] HEAD_READ = 4'h4;
  localparam logic [3:0] HEAD_WRITE = 4'h5;
  localparam logic [3:0] HEAD_READ_WRITE = 4'h9;
  localparam logic [7:0] REPLY_EXC_LEN = 8'h02;
  localparam logic [7:0] REPLY_WRITE_LEN = 8'h05;
  localparam logic [7:0] REPLY_READ_OVERHEAD = 8'h02;
  // relay and event log fields
  localparam logic [7:0] RELAY_ON = 8'h01;
  localparam logic [7:0] LOG_DEPTH = 8'h80;
  localparam int RECORD_WORDS = 256;
  localparam logic [7:0] MAX_SHORT_ADDR = 8'h3f;
  localparam logic [7:0] MIN_INSTANCE = 8'h01;
  localparam logic [7:0] MAX_INSTANCE = 8'h20;
  localparam logic [7:0] TYPE_BUTTON = 8'h01;
  localparam logic [7:0] TYPE_SLIDER = 8'h02;
  localparam logic [7:0] TYPE_OCCUPANCY = 8'h03;
  localparam logic [7:0] TYPE_LIGHT = 8'h04;
  localparam logic [7:0] KEY_FIRST = 8'h01;
  localparam logic [7:0] KEY_LAST = 8'h09;
  localparam logic [7:0] PERCENT_MAX = 8'h64;
  localparam logic [7:0] OCC_FIRST = 8'h01;
  localparam logic [7:0] OCC_LAST = 8'h03;

  typedef enum logic [5:0] {
    ST_FUNC = 6'b000001,
    ST_HEAD = 6'b000010,
    ST_CHECK = 6'b000100,
    ST_DATA = 6'b001000,
    ST_DROP = 6'b010000,
    ST_REPLY = 6'b100000
  } parse_state_t;

  // true when start..start+qty-1 lies inside first..last
  function automatic logic in_window(input logic [15:0] start, input logic [15:0] qty,
                                     input logic [15:0] first, input logic [15:0] last);
    logic [16:0] stop;
    stop = {1'b0, start} + {1'b0, qty} - 17'h0_0001;
    return (qty != 16'h0000) && (start >= first) && (stop <= {1'b0, last});
  endfunction
endpackage

// *** hw/reg_port_if.sv ***
`timescale 1ns/1ps
interface reg_port_if;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic [15:0] rdata;
  logic hit;
  modport master(output addr, output wdata, output wr, input rdata, input hit);
  modport slave(input addr, input wdata, input wr, output rdata, output hit);
endinterface

// *** hw/relay_bank.sv ***
`timescale 1ns/1ps
module relay_bank (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  reg_port_if.slave port,
  input wire logic [3:0] relay_sense,
  output logic [3:0] relay_drive
);
  logic [7:0] cmd [4];
  logic [3:0] sense_meta;
  logic [3:0] sense_sync;
  wire logic state_hit = lighting_regs_pkg::in_window(port.addr, lighting_regs_pkg::ONE_REG,
    lighting_regs_pkg::RELAY_STATE_FIRST, lighting_regs_pkg::RELAY_STATE_LAST);
  wire logic cmd_hit = lighting_regs_pkg::in_window(port.addr, lighting_regs_pkg::ONE_REG,
    lighting_regs_pkg::RELAY_CMD_FIRST, lighting_regs_pkg::RELAY_CMD_LAST);
  wire logic [15:0] state_off = port.addr - lighting_regs_pkg::RELAY_STATE_FIRST;
  wire logic [15:0] cmd_off = port.addr - lighting_regs_pkg::RELAY_CMD_FIRST;
  wire logic cmd_write = clk_en && port.wr && cmd_hit;

  assign port.hit = state_hit || cmd_hit;
  assign port.rdata = state_hit ? {15'h0000, sense_sync[state_off[1:0]]} :
                      cmd_hit ? {8'h00, cmd[cmd_off[1:0]]} : 16'h0000;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sense_meta <= 4'h0;
      sense_sync <= 4'h0;
    end else if (clk_en) begin
      sense_meta <= relay_sense;
      sense_sync <= sense_meta;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmd <= '{default: 8'h00};
      relay_drive <= 4'h0;
    end else if (cmd_write) begin
      cmd[cmd_off[1:0]] <= port.wdata[7:0];
      relay_drive[cmd_off[1:0]] <= (port.wdata[7:0] == lighting_regs_pkg::RELAY_ON);
    end
  end

  relay_drive_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmd_write && cmd_off[1:0] == 2'h0 |=>
      relay_drive[0] == ($past(port.wdata[7:0]) == lighting_regs_pkg::RELAY_ON))
    else $error("relay drive does not follow command");
  high_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    port.hit |-> port.rdata[15:8] == 8'h00)
    else $error("reserved high byte not zero");
endmodule

// *** hw/event_log.sv ***
`timescale 1ns/1ps
module event_log #(
  parameter logic [15:0] COUNT_ADDR = lighting_regs_pkg::BUS_A_COUNT,
  parameter logic [15:0] RECORD_ADDR = lighting_regs_pkg::BUS_A_RECORDS,
  parameter logic [15:0] LAST_ADDR = lighting_regs_pkg::BUS_A_LAST
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic evt_valid,
  input wire logic [31:0] evt_record,
  reg_port_if.slave port
);
  logic [15:0] mem [lighting_regs_pkg::RECORD_WORDS];
  logic [6:0] wr_ptr;
  logic [7:0] count;

  function automatic logic evt_legal(input logic [31:0] rec);
    logic ok;
    case (rec[15:8])
      lighting_regs_pkg::TYPE_BUTTON: ok = rec[7:0] >= lighting_regs_pkg::KEY_FIRST &&
                                           rec[7:0] <= lighting_regs_pkg::KEY_LAST;
      lighting_regs_pkg::TYPE_SLIDER, lighting_regs_pkg::TYPE_LIGHT:
        ok = rec[7:0] <= lighting_regs_pkg::PERCENT_MAX;
      lighting_regs_pkg::TYPE_OCCUPANCY: ok = rec[7:0] >= lighting_regs_pkg::OCC_FIRST &&
                                              rec[7:0] <= lighting_regs_pkg::OCC_LAST;
      default: ok = 1'b0;
    endcase
    return ok && rec[31:24] <= lighting_regs_pkg::MAX_SHORT_ADDR &&
           rec[23:16] >= lighting_regs_pkg::MIN_INSTANCE &&
           rec[23:16] <= lighting_regs_pkg::MAX_INSTANCE;
  endfunction

  wire logic log_en = clk_en && evt_valid && evt_legal(evt_record);
  wire logic count_hit = port.addr == COUNT_ADDR;
  wire logic rec_hit = lighting_regs_pkg::in_window(port.addr, lighting_regs_pkg::ONE_REG,
    RECORD_ADDR, LAST_ADDR);
  wire logic [15:0] rec_off = port.addr - RECORD_ADDR;

  assign port.hit = count_hit || rec_hit;
  assign port.rdata = count_hit ? {8'h00, count} : rec_hit ? mem[rec_off[7:0]] : 16'h0000;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mem <= '{default: 16'h0000};
      wr_ptr <= 7'h00;
    end else if (log_en) begin
      mem[{wr_ptr, 1'b0}] <= evt_record[31:16];
      mem[{wr_ptr, 1'b1}] <= evt_record[15:0];
      wr_ptr <= wr_ptr + 7'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count <= 8'h00;
    end else if (log_en) begin
      count <= (count == lighting_regs_pkg::LOG_DEPTH) ? 8'h01 : count + 8'h01;
    end
  end

  count_range_a: assert property (@(posedge sys_clk) disable iff (reset)
    count <= lighting_regs_pkg::LOG_DEPTH)
    else $error("event count above depth");
  count_wrap_a: assert property (@(posedge sys_clk) disable iff (reset)
    log_en && count == lighting_regs_pkg::LOG_DEPTH |=> count == 8'h01 && wr_ptr == 7'h01)
    else $error("event count did not restart");
  ptr_wrap_a: assert property (@(posedge sys_clk) disable iff (reset)
    log_en && wr_ptr == 7'h7f |=> wr_ptr == 7'h00 && mem[8'hff] == $past(evt_record[15:0]))
    else $error("record area did not wrap");
endmodule

// *** hw/relay_event_regs.sv ***
`timescale 1ns/1ps
// What this block does
// - relay follows command low byte
// - status register shows relay state
// - bus A count zero to 128
// - count restarts after passing 128
// - two registers per event, 128 events
// - bus A records overwrite circularly
// - bus B records overwrite circularly
// - address and instance in bytes 0,1
// - byte 2 holds instance type
// - button key event codes in byte 3
// - slider or brightness percent in byte 3
// - occupancy codes in byte 3
// - bus B keeps own count
// - bus B own record area
// - read/write multiple does both parts
// - read reply: code, count, data
// - write reply echoes start and quantity
// - bad code or data gets exception
module relay_event_regs (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic bus_a_evt_valid,
  input wire logic [31:0] bus_a_evt_record,
  input wire logic bus_b_evt_valid,
  input wire logic [31:0] bus_b_evt_record,
  input wire logic [3:0] relay_sense,
  output logic [3:0] relay_drive
);
  lighting_regs_pkg::parse_state_t state;
  lighting_regs_pkg::parse_state_t next_state;
  logic [7:0] func;
  logic [7:0] head [9];
  logic [3:0] head_cnt;
  logic [7:0] data_cnt;
  logic [7:0] high_byte;
  logic [7:0] exc;
  logic [7:0] next_exc;
  logic last_seen;
  logic [7:0] tx_idx;

  reg_port_if relay_port();
  reg_port_if a_port();
  reg_port_if b_port();

  function automatic logic fc_supported(input logic [7:0] code);
    return code == lighting_regs_pkg::FC_READ_HOLDING ||
           code == lighting_regs_pkg::FC_READ_INPUT ||
           code == lighting_regs_pkg::FC_WRITE_MULTI || code == lighting_regs_pkg::FC_READ_WRITE;
  endfunction

  // request decode
  wire logic take = clk_en && rx_valid && rx_ready;
  wire logic is_rw = func == lighting_regs_pkg::FC_READ_WRITE;
  wire logic is_write = func == lighting_regs_pkg::FC_WRITE_MULTI;
  wire logic reads = !is_write;
  wire logic writes = is_write || is_rw;
  wire logic [3:0] head_len = is_rw ? lighting_regs_pkg::HEAD_READ_WRITE :
                              is_write ? lighting_regs_pkg::HEAD_WRITE :
                              lighting_regs_pkg::HEAD_READ;
  wire logic [15:0] rd_start = {head[0], head[1]};
  wire logic [15:0] rd_qty = {head[2], head[3]};
  wire logic [15:0] wr_start = is_rw ? {head[4], head[5]} : {head[0], head[1]};
  wire logic [15:0] wr_qty = is_rw ? {head[6], head[7]} : {head[2], head[3]};
  wire logic [7:0] byte_cnt = is_rw ? head[8] : head[4];
  wire logic head_last = head_cnt == head_len - 4'h1;
  wire logic data_last = data_cnt + 8'h01 == byte_cnt;

  wire logic rd_span_ok =
    lighting_regs_pkg::in_window(rd_start, rd_qty, lighting_regs_pkg::RELAY_STATE_FIRST,
                                 lighting_regs_pkg::RELAY_STATE_LAST) ||
    lighting_regs_pkg::in_window(rd_start, rd_qty, lighting_regs_pkg::RELAY_CMD_FIRST,
                                 lighting_regs_pkg::RELAY_CMD_LAST) ||
    lighting_regs_pkg::in_window(rd_start, rd_qty, lighting_regs_pkg::BUS_A_COUNT,
                                 lighting_regs_pkg::BUS_A_LAST) ||
    lighting_regs_pkg::in_window(rd_start, rd_qty, lighting_regs_pkg::BUS_B_COUNT,
                                 lighting_regs_pkg::BUS_B_LAST);
  wire logic rd_ok = !reads || (rd_qty <= lighting_regs_pkg::MAX_READ_QTY && rd_span_ok);
  wire logic wr_ok = !writes || (wr_qty <= lighting_regs_pkg::MAX_WRITE_QTY &&
    lighting_regs_pkg::in_window(wr_start, wr_qty, lighting_regs_pkg::RELAY_CMD_FIRST,
                                 lighting_regs_pkg::RELAY_CMD_LAST) &&
    {8'h00, byte_cnt} == {wr_qty[14:0], 1'b0});
  wire logic head_ok = rd_ok && wr_ok;

  // reply framing
  wire logic has_exc = exc != lighting_regs_pkg::EXC_NONE;
  wire logic [7:0] read_bytes = {rd_qty[6:0], 1'b0};
  wire logic [7:0] reply_len = has_exc ? lighting_regs_pkg::REPLY_EXC_LEN :
                               is_write ? lighting_regs_pkg::REPLY_WRITE_LEN :
                               lighting_regs_pkg::REPLY_READ_OVERHEAD + read_bytes;
  wire logic [7:0] body_idx = tx_idx - lighting_regs_pkg::REPLY_READ_OVERHEAD;
  wire logic [15:0] read_addr = rd_start + {9'h000, body_idx[7:1]};
  wire logic [15:0] write_addr = wr_start + {9'h000, data_cnt[7:1]};
  wire logic [15:0] port_addr = (state == lighting_regs_pkg::ST_REPLY) ? read_addr : write_addr;
  wire logic [15:0] read_word = relay_port.rdata | a_port.rdata | b_port.rdata;
  wire logic tx_more = tx_idx != reply_len;
  wire logic tx_load = clk_en && state == lighting_regs_pkg::ST_REPLY && tx_more &&
                       (!tx_valid || tx_ready);
  wire logic tx_done = clk_en && tx_valid && tx_ready && tx_last;

  wire logic [7:0] echo_byte = (tx_idx == 8'h01) ? wr_start[15:8] :
                               (tx_idx == 8'h02) ? wr_start[7:0] :
                               (tx_idx == 8'h03) ? wr_qty[15:8] : wr_qty[7:0];
  wire logic [7:0] reply_byte = (tx_idx == 8'h00) ?
                                  (has_exc ? func | lighting_regs_pkg::EXC_FLAG : func) :
                                has_exc ? exc :
                                is_write ? echo_byte :
                                (tx_idx == 8'h01) ? read_bytes :
                                body_idx[0] ? read_word[7:0] : read_word[15:8];

  assign rx_ready = state == lighting_regs_pkg::ST_FUNC || state == lighting_regs_pkg::ST_HEAD ||
                    state == lighting_regs_pkg::ST_DATA || state == lighting_regs_pkg::ST_DROP;

  assign relay_port.addr = port_addr;
  assign relay_port.wdata = {high_byte, rx_data};
  assign relay_port.wr = take && state == lighting_regs_pkg::ST_DATA && data_cnt[0];
  assign a_port.addr = port_addr;
  assign a_port.wdata = 16'h0000;
  assign a_port.wr = 1'b0;
  assign b_port.addr = port_addr;
  assign b_port.wdata = 16'h0000;
  assign b_port.wr = 1'b0;

  relay_bank u_relays (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .port(relay_port.slave),
    .relay_sense(relay_sense),
    .relay_drive(relay_drive)
  );

  event_log #(
    .COUNT_ADDR(lighting_regs_pkg::BUS_A_COUNT),
    .RECORD_ADDR(lighting_regs_pkg::BUS_A_RECORDS),
    .LAST_ADDR(lighting_regs_pkg::BUS_A_LAST)
  ) u_log_a (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .evt_valid(bus_a_evt_valid),
    .evt_record(bus_a_evt_record),
    .port(a_port.slave)
  );

  event_log #(
    .COUNT_ADDR(lighting_regs_pkg::BUS_B_COUNT),
    .RECORD_ADDR(lighting_regs_pkg::BUS_B_RECORDS),
    .LAST_ADDR(lighting_regs_pkg::BUS_B_LAST)
  ) u_log_b (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .evt_valid(bus_b_evt_valid),
    .evt_record(bus_b_evt_record),
    .port(b_port.slave)
  );

  always_comb begin
    next_state = state;
    next_exc = exc;
    case (state)
      lighting_regs_pkg::ST_FUNC: begin
        if (take) begin
          if (!fc_supported(rx_data)) begin
            next_exc = lighting_regs_pkg::EXC_BAD_FUNCTION;
            next_state = rx_last ? lighting_regs_pkg::ST_REPLY : lighting_regs_pkg::ST_DROP;
          end else if (rx_last) begin
            next_exc = lighting_regs_pkg::EXC_BAD_DATA;
            next_state = lighting_regs_pkg::ST_REPLY;
          end else begin
            next_exc = lighting_regs_pkg::EXC_NONE;
            next_state = lighting_regs_pkg::ST_HEAD;
          end
        end
      end
      lighting_regs_pkg::ST_HEAD: begin
        if (take && head_last) begin
          next_state = lighting_regs_pkg::ST_CHECK;
        end else if (take && rx_last) begin
          next_exc = lighting_regs_pkg::EXC_BAD_DATA;
          next_state = lighting_regs_pkg::ST_REPLY;
        end
      end
      lighting_regs_pkg::ST_CHECK: begin
        if (!head_ok || (writes == last_seen)) begin
          next_exc = lighting_regs_pkg::EXC_BAD_DATA;
          next_state = last_seen ? lighting_regs_pkg::ST_REPLY : lighting_regs_pkg::ST_DROP;
        end else begin
          next_state = writes ? lighting_regs_pkg::ST_DATA : lighting_regs_pkg::ST_REPLY;
        end
      end
      lighting_regs_pkg::ST_DATA: begin
        if (take && data_last) begin
          next_exc = rx_last ? lighting_regs_pkg::EXC_NONE : lighting_regs_pkg::EXC_BAD_DATA;
          next_state = rx_last ? lighting_regs_pkg::ST_REPLY : lighting_regs_pkg::ST_DROP;
        end else if (take && rx_last) begin
          next_exc = lighting_regs_pkg::EXC_BAD_DATA;
          next_state = lighting_regs_pkg::ST_REPLY;
        end
      end
      lighting_regs_pkg::ST_DROP: begin
        if (take && rx_last) begin
          next_state = lighting_regs_pkg::ST_REPLY;
        end
      end
      lighting_regs_pkg::ST_REPLY: begin
        if (tx_done) begin
          next_state = lighting_regs_pkg::ST_FUNC;
        end
      end
      default: begin
        next_state = lighting_regs_pkg::ST_FUNC;
        next_exc = lighting_regs_pkg::EXC_NONE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= lighting_regs_pkg::ST_FUNC;
      exc <= 8'h00;
    end else if (clk_en) begin
      state <= next_state;
      exc <= next_exc;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      func <= 8'h00;
      last_seen <= 1'b0;
    end else if (take) begin
      if (state == lighting_regs_pkg::ST_FUNC) begin
        func <= rx_data;
      end
      last_seen <= rx_last;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      head <= '{default: 8'h00};
      head_cnt <= 4'h0;
    end else if (take && state == lighting_regs_pkg::ST_FUNC) begin
      head_cnt <= 4'h0;
    end else if (take && state == lighting_regs_pkg::ST_HEAD) begin
      head[head_cnt] <= rx_data;
      head_cnt <= head_cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_cnt <= 8'h00;
      high_byte <= 8'h00;
    end else if (take && state == lighting_regs_pkg::ST_FUNC) begin
      data_cnt <= 8'h00;
    end else if (take && state == lighting_regs_pkg::ST_DATA) begin
      data_cnt <= data_cnt + 8'h01;
      high_byte <= rx_data;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_idx <= 8'h00;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
    end else if (clk_en) begin
      if (state != lighting_regs_pkg::ST_REPLY) begin
        tx_idx <= 8'h00;
      end else if (tx_load) begin
        tx_idx <= tx_idx + 8'h01;
      end
      if (tx_load) begin
        tx_data <= reply_byte;
        tx_valid <= 1'b1;
        tx_last <= tx_idx + 8'h01 == reply_len;
      end else if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
        tx_last <= 1'b0;
      end
    end
  end

  exc_code_a: assert property (@(posedge sys_clk) disable iff (reset)
    tx_valid && tx_idx == 8'h01 && has_exc |-> tx_data == (func | lighting_regs_pkg::EXC_FLAG))
    else $error("exception reply lacks flagged function code");
  exc_len_a: assert property (@(posedge sys_clk) disable iff (reset)
    tx_valid && tx_idx == 8'h02 && has_exc |-> tx_data == exc && tx_last)
    else $error("exception reply wrong length or code");
  read_count_a: assert property (@(posedge sys_clk) disable iff (reset)
    tx_valid && tx_idx == 8'h02 && !has_exc && reads |-> tx_data == {rd_qty[6:0], 1'b0})
    else $error("read reply byte count wrong");
  write_echo_a: assert property (@(posedge sys_clk) disable iff (reset)
    tx_valid && tx_idx == 8'h05 && !has_exc && is_write |-> tx_data == wr_qty[7:0] && tx_last)
    else $error("write reply echo wrong");
  reply_end_a: assert property (@(posedge sys_clk) disable iff (reset)
    tx_done |=> state == lighting_regs_pkg::ST_FUNC && !tx_valid)
    else $error("reply did not end the transaction");
  reply_busy_a: assert property (@(posedge sys_clk) disable iff (reset)
    state == lighting_regs_pkg::ST_REPLY |-> !rx_ready)
    else $error("request taken during reply");
  read_hit_a: assert property (@(posedge sys_clk) disable iff (reset)
    tx_load && !has_exc && reads && tx_idx >= lighting_regs_pkg::REPLY_READ_OVERHEAD |->
      relay_port.hit || a_port.hit || b_port.hit)
    else $error("reply read from unmapped register");
  reply_func_a: assert property (@(posedge sys_clk) disable iff (reset)
    tx_valid && tx_idx == 8'h01 && !has_exc |-> tx_data == func)
    else $error("reply does not start with function code");
  write_start_a: assert property (@(posedge sys_clk) disable iff (reset)
    tx_valid && tx_idx == 8'h03 && !has_exc && is_write |-> tx_data == wr_start[7:0])
    else $error("write reply start address wrong");
  tx_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("reply byte changed before it was taken");
  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
    state == lighting_regs_pkg::ST_FUNC |-> !tx_valid)
    else $error("reply byte outside a reply");
  bad_func_a: assert property (@(posedge sys_clk) disable iff (reset)
    take && state == lighting_regs_pkg::ST_FUNC && !fc_supported(rx_data) |=>
      exc == lighting_regs_pkg::EXC_BAD_FUNCTION)
    else $error("unsupported function not flagged");
  bad_head_a: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && state == lighting_regs_pkg::ST_CHECK && !head_ok |=>
      exc == lighting_regs_pkg::EXC_BAD_DATA)
    else $error("malformed request not flagged");
endmodule

// *** testbench/modbus_client.sv ***
`timescale 1ns/1ps
module modbus_client (
  input wire logic sys_clk,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  typedef logic [7:0] bytes_t[$];
  bit slow = 0;
  initial begin
    rx_valid = 0;
    rx_data = 8'h00;
    rx_last = 0;
    tx_ready = 0;
  end
  task automatic transact(input bytes_t req, output bytes_t rsp);
    int n;
    rsp = {};
    foreach (req[i]) begin
      @(negedge sys_clk);
      rx_valid = 1;
      rx_data = req[i];
      rx_last = (i == req.size() - 1);
      do @(posedge sys_clk); while (rx_ready !== 1'b1);
    end
    @(negedge sys_clk);
    rx_valid = 0;
    rx_data = ~rx_data;
    rx_last = 0;
    for (n = 0; n < 300; n++) begin
      @(negedge sys_clk);
      tx_ready = !slow || n[0];
      @(posedge sys_clk);
      if (tx_valid === 1'b1 && tx_ready) begin
        rsp.push_back(tx_data);
        if (tx_last === 1'b1) break;
      end
    end
    @(negedge sys_clk);
    tx_ready = 0;
  endtask
endmodule

// *** testbench/relay_event_regs_test.sv ***
`timescale 1ns/1ps
module relay_event_regs_test;
  logic sys_clk = 0;
  logic reset = 1;
  logic rx_valid, rx_ready, rx_last, tx_valid, tx_ready, tx_last;
  logic [7:0] rx_data, tx_data;
  logic bus_a_evt_valid = 0, bus_b_evt_valid = 0, clk_en = 1;
  logic [31:0] bus_a_evt_record = '0, bus_b_evt_record = '0;
  logic [3:0] relay_sense = 4'h9, relay_drive;
  int failures = 0, total_checks = 0;
  logic [7:0] rsp[$], q[$];
  relay_event_regs u_relay_event_regs (.sys_clk, .reset, .clk_en, .rx_valid, .rx_ready,
    .rx_data, .rx_last, .tx_valid, .tx_ready, .tx_data, .tx_last, .bus_a_evt_valid,
    .bus_a_evt_record, .bus_b_evt_valid, .bus_b_evt_record, .relay_sense, .relay_drive);
  modbus_client u_modbus_client (.sys_clk, .rx_valid, .rx_ready, .rx_data, .rx_last,
    .tx_valid, .tx_ready, .tx_data, .tx_last);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] req[$], input logic [7:0] exp[$]);
    u_modbus_client.transact(req, rsp);
    check(rsp.size(), exp.size(), "reply length");
    foreach (exp[i]) check(rsp[i], exp[i], "reply byte");
  endtask
  function automatic logic [31:0] ev(input bit b, input int k);
    return {8'(k % 64), 8'(k % 32 + 1), b ? 8'(2 + k % 3) : 8'h01,
            b ? 8'(1 + k % 3) : 8'(1 + k % 9)};
  endfunction
  task automatic log_event(input bit b, input logic [31:0] rec);
    @(negedge sys_clk);
    bus_a_evt_valid = !b;
    bus_b_evt_valid = b;
    if (b) bus_b_evt_record = rec;
    else bus_a_evt_record = rec;
    @(negedge sys_clk);
    bus_a_evt_valid = 0;
    bus_b_evt_valid = 0;
  endtask
  task automatic add_rec(input bit b, input int k);
    logic [31:0] w;
    w = ev(b, k);
    for (int j = 3; j >= 0; j--) q.push_back(w[8*j+:8]);
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 0;
    run({8'h10, 8'ha7, 8'hf9, 8'h00, 8'h04, 8'h08, 8'h00, 8'h01, 8'h00, 8'h00, 8'hff, 8'h01,
      8'h00, 8'h02}, {8'h10, 8'ha7, 8'hf9, 8'h00, 8'h04});
    check(relay_drive, 4'b0101, "relay drive");
    run({8'h03, 8'ha7, 8'hf9, 8'h00, 8'h04}, {8'h03, 8'h08, 8'h00, 8'h01, 8'h00, 8'h00,
      8'h00, 8'h01, 8'h00, 8'h02});
    u_modbus_client.slow = 1;
    run({8'h17, 8'h80, 8'he9, 8'h00, 8'h04, 8'ha7, 8'hf9, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00},
      {8'h17, 8'h08, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h01});
    check(relay_drive, 4'b0100, "relay drive after rw");
    log_event(1, 32'h0101_0501);
    for (int k = 0; k < 130; k++) begin
      log_event(0, ev(0, k));
      if (k < 129) log_event(1, ev(1, k));
      if (k == 127) run({8'h03, 8'h84, 8'hd1, 8'h00, 8'h01},
        {8'h03, 8'h02, 8'h00, 8'h80});
    end
    clk_en = 0;
    log_event(0, ev(0, 7));
    clk_en = 1;
    q = {8'h03, 8'h0a, 8'h00, 8'h02};
    add_rec(0, 128);
    add_rec(0, 129);
    run({8'h03, 8'h84, 8'hd1, 8'h00, 8'h05}, q);
    q = {8'h04, 8'h0a, 8'h00, 8'h01};
    add_rec(1, 128);
    add_rec(1, 1);
    run({8'h04, 8'h88, 8'hb9, 8'h00, 8'h05}, q);
    run({8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, {8'h85, 8'h01});
    run({8'h03, 8'h84, 8'hd2, 8'h00, 8'h00}, {8'h83, 8'h03});
    run({8'h10, 8'h80, 8'he9, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01}, {8'h90, 8'h03});
    wrap_up;
  end
  initial begin
    #200us;
    failures++;
    wrap_up;
  end
endmodule
